// *** hdl/sfo_sync_output.v ***
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sfo_map.vh"
module sfo_sync_output #(
	parameter REP_W = 2
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire [9:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [9:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	input  wire             digitalPath,
	input  wire [REP_W-1:0] pixelRepeat,
	input  wire             rawHsyncPin,
	input  wire             rawVsyncPin,
	input  wire             greenSyncPin,
	input  wire             clampPin,
	input  wire             regenHsync,
	input  wire             filtHsync,
	input  wire             dataEnableIn,
	input  wire             fieldIn,
	output reg              pllHsync,
	output reg              procHsync,
	output reg              aoSample,
	output reg              outHsync,
	output reg              outVsync,
	output reg              outDataEnable,
	output reg              outField,
	output reg              green_embedded_sync,
	output reg              outClk
);
	// ----------------------------------------
	// registers and bus state
	// ----------------------------------------
	reg  [7:0] pathCtl;
	reg  [7:0] vDur;
	reg  [7:0] hWidth;
	reg  [7:0] polSel;
	reg  [7:0] clkDrive;
	reg  [9:0] wrAddr;
	reg        haveAw;
	reg  [7:0] wrData;
	reg        wrLane;
	reg        haveW;
	wire [3:0] pinLevel;
	wire       rawHs;
	wire       rawVs;
	wire       greenIn;
	wire       clampIn;
	reg        vsActive;
	reg  [2:0] clkPhase;

	// shared decode for reads and writes
	function [2:0] decode;
		input [9:0] addr;
		begin
			case (addr)
				`SFO_ADDR_PATH: decode = 3'd1;
				`SFO_ADDR_VDUR: decode = 3'd2;
				`SFO_ADDR_HWID: decode = 3'd3;
				`SFO_ADDR_POL:  decode = 3'd4;
				`SFO_ADDR_CLK:  decode = 3'd5;
				`SFO_ADDR_STAT: decode = 3'd6;
				default:        decode = 3'd0;
			endcase
		end
	endfunction

	sfo_edge_sync #(
		.WIDTH (4)
	) pinSync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.pinIn    ({clampPin, greenSyncPin, rawVsyncPin, rawHsyncPin}),
		.levelOut (pinLevel)
	);
	assign rawHs   = pinLevel[0];
	assign rawVs   = pinLevel[1];
	assign greenIn = pinLevel[2];
	assign clampIn = pinLevel[3];

	// ----------------------------------------
	// axi4-lite write: address and data taken in either order
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			haveAw        <= 1'b0;
			haveW         <= 1'b0;
			wrAddr        <= 10'h000;
			wrData        <= 8'h00;
			wrLane        <= 1'b0;
			pathCtl       <= `SFO_RST_PATH;
			vDur          <= `SFO_RST_VDUR;
			hWidth        <= `SFO_RST_HWID;
			polSel        <= `SFO_RST_POL;
			clkDrive      <= `SFO_RST_CLK;
		end else begin
			s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				haveAw <= 1'b1;
				wrAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				haveW  <= 1'b1;
				wrData <= s_axi_wdata[7:0];
				wrLane <= s_axi_wstrb[0];
			end
			// registers hold until a full write arrives
			if (haveAw && haveW) begin
				haveAw       <= 1'b0;
				haveW        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (decode(wrAddr) == 3'd0 || decode(wrAddr) == 3'd6) ?
					2'b10 : 2'b00;
				if (wrLane) begin
					case (decode(wrAddr))
						3'd1: pathCtl  <= wrData;
						3'd2: vDur     <= wrData;
						3'd3: hWidth   <= wrData;
						3'd4: polSel   <= wrData;
						3'd5: clkDrive <= wrData;
						default: pathCtl <= pathCtl;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read, unmapped answers slverr with zero data
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (decode(s_axi_araddr) == 3'd0) ? 2'b10 : 2'b00;
				case (decode(s_axi_araddr))
					3'd1: s_axi_rdata <= {24'h00_0000, pathCtl};
					3'd2: s_axi_rdata <= {24'h00_0000, vDur};
					3'd3: s_axi_rdata <= {24'h00_0000, hWidth};
					3'd4: s_axi_rdata <= {24'h00_0000, polSel};
					3'd5: s_axi_rdata <= {24'h00_0000, clkDrive};
					3'd6: s_axi_rdata <= {24'h00_0000, vsActive, aoSample, procHsync,
						pllHsync, outHsync, outVsync, clkPhase[1:0]};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// hsync routing
	// ----------------------------------------
	reg        hsPrev;
	reg  [7:0] hsCount;
	reg        hsPulse;
	wire       hsRise;
	assign hsRise = procHsync && !hsPrev;

	// pll and processing hsync sources
	always @(posedge clk) begin
		if (sys_rst) begin
			pllHsync  <= 1'b0;
			procHsync <= 1'b0;
			hsPrev    <= 1'b0;
		end else begin
			pllHsync  <= pathCtl[`SFO_B_PLLF] ? filtHsync : rawHs;
			procHsync <= pathCtl[`SFO_B_REGEN] ? regenHsync : rawHs;
			hsPrev    <= procHsync;
		end
	end

	// output hsync width counter; width 0 gives no pulse
	always @(posedge clk) begin
		if (sys_rst) begin
			hsCount <= 8'h00;
			hsPulse <= 1'b0;
		end else if (hsRise && hWidth != 8'h00) begin
			hsCount <= hWidth - 8'h01;
			hsPulse <= 1'b1;
		end else if (hsCount != 8'h00) begin
			hsCount <= hsCount - 8'h01;
		end else begin
			hsPulse <= 1'b0;
		end
	end

	// ----------------------------------------
	// vsync filter and duration restore
	// ----------------------------------------
	reg        vsAligned;
	reg        vsPrev;
	reg  [7:0] vsCount;
	reg        vsRestored;
	wire       vsFiltered;

	// sampling vsync on hsync edges fixes the relation but delays both edges by up to one line
	always @(posedge clk) begin
		if (sys_rst) begin
			vsAligned <= 1'b0;
		end else if (hsRise) begin
			vsAligned <= rawVs;
		end
	end
	assign vsFiltered = pathCtl[`SFO_B_VFILT] ? vsAligned : rawVs;

	// duration counted in processing hsync periods
	always @(posedge clk) begin
		if (sys_rst) begin
			vsPrev     <= 1'b0;
			vsCount    <= 8'h00;
			vsRestored <= 1'b0;
			vsActive   <= 1'b0;
		end else begin
			vsPrev <= vsFiltered;
			if (vsFiltered && !vsPrev && vDur != 8'h00) begin
				vsCount    <= vDur;
				vsRestored <= 1'b1;
			end else if (vsRestored && hsRise) begin
				vsCount <= vsCount - 8'h01;
				if (vsCount == 8'h01) begin
					vsRestored <= 1'b0;
				end
			end
			vsActive <= pathCtl[`SFO_B_VDUR] ? vsRestored : vsFiltered;
		end
	end

	// ----------------------------------------
	// auto-offset sampling window
	// ----------------------------------------
	localparam AO_IDLE = 2'd0;
	localparam AO_WAIT = 2'd1;
	localparam AO_RUN  = 2'd2;
	reg  [1:0] aoState;
	reg  [4:0] aoCount;
	reg        clampPrev;

	always @(posedge clk) begin
		if (sys_rst) begin
			aoState   <= AO_IDLE;
			aoCount   <= 5'd0;
			aoSample  <= 1'b0;
			clampPrev <= 1'b0;
		end else begin
			clampPrev <= clampIn;
			if (!pathCtl[`SFO_B_AOMODE]) begin
				aoState  <= AO_IDLE;
				aoSample <= clampIn;
			end else begin
				case (aoState)
					AO_IDLE: begin
						aoSample <= 1'b0;
						if (clampPrev && !clampIn) begin
							aoState <= AO_WAIT;
							aoCount <= (pathCtl[`SFO_B_AOLEN] ? `SFO_AO_DELAY_LONG
								: `SFO_AO_DELAY_SHORT) - 5'd1;
						end
					end
					AO_WAIT: begin
						if (aoCount == 5'd1) begin
							aoState  <= AO_RUN;
							aoSample <= 1'b1;
							aoCount  <= {2'b00, `SFO_AO_SAMPLES};
						end else begin
							aoCount <= aoCount - 5'd1;
						end
					end
					AO_RUN: begin
						if (aoCount == 5'd1) begin
							aoState  <= AO_IDLE;
							aoSample <= 1'b0;
						end else begin
							aoCount <= aoCount - 5'd1;
						end
					end
					default: aoState <= AO_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// output polarity and green sync pin
	// ----------------------------------------
	reg greenSrc;
	always @* begin
		case (polSel[`SFO_B_GSEL_HI:`SFO_B_GSEL_LO])
			2'b00:   greenSrc = greenIn;
			2'b01:   greenSrc = rawHs;
			2'b10:   greenSrc = regenHsync;
			default: greenSrc = pllHsync;
		endcase
	end

	// a polarity bit of 0 inverts the active-high internal level
	always @(posedge clk) begin
		if (sys_rst) begin
			outHsync            <= 1'b1;
			outVsync            <= 1'b1;
			outDataEnable       <= 1'b1;
			outField            <= 1'b1;
			green_embedded_sync <= 1'b1;
		end else begin
			outHsync      <= ~(hsPulse ^ polSel[`SFO_B_HPOL]);
			outVsync      <= ~(vsActive ^ polSel[`SFO_B_VPOL]);
			outDataEnable <= ~(dataEnableIn ^ polSel[`SFO_B_DEPOL]);
			outField      <= ~(fieldIn ^ polSel[`SFO_B_FPOL]);
			// digital path keeps the green pin at its selected, uninverted source
			green_embedded_sync <= digitalPath ? greenSrc
				: ~(greenSrc ^ polSel[`SFO_B_GPOL]);
		end
	end

	// ----------------------------------------
	// output clock: every rate is a tap of one phase counter, so 2x tops out at clk/2
	// ----------------------------------------
	reg  [REP_W-1:0] repCount;
	reg              oneXEn;
	reg              next_outClk;

	// pixel repetition divides the link clock down to the 1x rate
	always @(posedge clk) begin
		if (sys_rst) begin
			repCount <= {REP_W{1'b0}};
			oneXEn   <= 1'b1;
		end else if (digitalPath && pixelRepeat != {REP_W{1'b0}}) begin
			oneXEn   <= (repCount == pixelRepeat);
			repCount <= (repCount == pixelRepeat) ? {REP_W{1'b0}} : repCount + 1'b1;
		end else begin
			oneXEn   <= 1'b1;
			repCount <= {REP_W{1'b0}};
		end
	end

	// phase counter: bit 0 is 2x, bit 1 is 1x, bit 2 is half rate
	always @(posedge clk) begin
		if (sys_rst) begin
			clkPhase <= 3'd0;
		end else if (oneXEn) begin
			clkPhase <= clkPhase + 3'd1;
		end
	end

	always @* begin
		case (clkDrive[`SFO_B_CSEL_HI:`SFO_B_CSEL_LO])
			2'b00:   next_outClk = clkPhase[2];
			2'b01:   next_outClk = clkPhase[1];
			2'b10:   next_outClk = clkPhase[0];
			default: next_outClk = clkPhase[1] ^ clkPhase[0];   // a quarter period off 1x
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			outClk <= 1'b0;
		end else begin
			outClk <= next_outClk ^ polSel[`SFO_B_CINV];
		end
	end
endmodule

// *** shared/sfo_map.vh ***
`ifndef SFO_MAP_VH
`define SFO_MAP_VH
// register byte addresses (printed offsets are not multiples of four: index times four)
`define SFO_IDX_PATH        8'h21
`define SFO_IDX_VDUR        8'h22
`define SFO_IDX_HWID        8'h23
`define SFO_IDX_POL         8'h24
`define SFO_IDX_CLK         8'h25
`define SFO_IDX_STAT        8'h30
`define SFO_ADDR_PATH       10'h084
`define SFO_ADDR_VDUR       10'h088
`define SFO_ADDR_HWID       10'h08C
`define SFO_ADDR_POL        10'h090
`define SFO_ADDR_CLK        10'h094
`define SFO_ADDR_STAT       10'h0C0
// field positions
`define SFO_B_REGEN         7
`define SFO_B_PLLF          6
`define SFO_B_VFILT         5
`define SFO_B_VDUR          4
`define SFO_B_AOMODE        3
`define SFO_B_AOLEN         2
`define SFO_B_HPOL          7
`define SFO_B_VPOL          6
`define SFO_B_DEPOL         5
`define SFO_B_FPOL          4
`define SFO_B_GPOL          3
`define SFO_B_GSEL_HI       2
`define SFO_B_GSEL_LO       1
`define SFO_B_CINV          0
`define SFO_B_CSEL_HI       7
`define SFO_B_CSEL_LO       6
// reset values
`define SFO_RST_PATH        8'hCC
`define SFO_RST_VDUR        8'h04
`define SFO_RST_HWID        8'h20
`define SFO_RST_POL         8'hFE
`define SFO_RST_CLK         8'h70
// timing counts in clocks
`define SFO_AO_DELAY_SHORT  5'd10
`define SFO_AO_DELAY_LONG   5'd16
`define SFO_AO_SAMPLES      3'd6
`endif

// *** hdl/sfo_edge_sync.v ***
`timescale 1ns/1ps
// ----------------------------------------
// three-stage pin synchroniser, change accepted when stages two and three agree
// ----------------------------------------
module sfo_edge_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] pinIn,
	output reg  [WIDTH-1:0] levelOut
);
	reg [WIDTH-1:0] stageA;
	reg [WIDTH-1:0] stageB;
	reg [WIDTH-1:0] stageC;

	// stageA feeds stageB only, to keep metastability away from logic
	always @(posedge clk) begin
		if (sys_rst) begin
			stageA   <= {WIDTH{1'b0}};
			stageB   <= {WIDTH{1'b0}};
			stageC   <= {WIDTH{1'b0}};
			levelOut <= {WIDTH{1'b0}};
		end else begin
			stageA <= pinIn;
			stageB <= stageA;
			stageC <= stageB;
			// follow stage three once it agrees with stage two, otherwise hold
			levelOut <= ((stageB ~^ stageC) & stageC) | ((stageB ^ stageC) & levelOut);
		end
	end
endmodule

// *** verification/sfo_sync_output_asserts.sv ***
`timescale 1ns/1ps
`include "sfo_map.vh"
// ----------------------------------------
// port-level checks of the sync output block
// ----------------------------------------
module sfo_sync_output_chk (
	input wire        clk,
	input wire        sys_rst,
	input wire [9:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        regenHsync,
	input wire        filtHsync,
	input wire        dataEnableIn,
	input wire        pllHsync,
	input wire        procHsync,
	input wire        aoSample,
	input wire        outDataEnable
);
	reg [9:0] wAddr;
	reg [7:0] wByte;
	reg       wEn;
	reg [7:0] path;
	reg [7:0] pol;
	reg [1:0] settle;
	// shadow of path and polarity, applied when the write response is taken
	always @(posedge clk) begin
		if (s_axi_awvalid && s_axi_awready) wAddr <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) begin
			wByte <= s_axi_wdata[7:0];
			wEn <= s_axi_wstrb[0];
		end
		if (sys_rst) begin
			path <= `SFO_RST_PATH;
			pol <= `SFO_RST_POL;
		end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00 && wEn) begin
			if (wAddr == `SFO_ADDR_PATH) path <= wByte;
			if (wAddr == `SFO_ADDR_POL) pol <= wByte;
		end
	end
	// the shadow lags the real register, so hold off checks around a write
	always @(posedge clk) begin
		if (sys_rst || s_axi_bvalid) settle <= 2'd0;
		else if (settle != 2'd3) settle <= settle + 2'd1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	de_polarity_a: assert property (settle != 2'd0 |->
		outDataEnable == ($past(dataEnableIn) ~^ pol[`SFO_B_DEPOL])) else $error("de level wrong");
	pll_route_a: assert property (settle != 2'd0 && path[`SFO_B_PLLF] |->
		pllHsync == $past(filtHsync)) else $error("pll sync not filtered");
	proc_route_a: assert property (settle != 2'd0 && path[`SFO_B_REGEN] |->
		procHsync == $past(regenHsync)) else $error("proc sync not regenerated");
	ao_window_a: assert property (settle != 2'd0 && path[`SFO_B_AOMODE] && $rose(aoSample)
		|-> aoSample [*6] ##1 !aoSample) else $error("sample window not six");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
		|-> ##[1:6] s_axi_bvalid) else $error("no write response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data");
	ar_taken_a: assert property (s_axi_arvalid |-> ##[0:2] s_axi_arready)
		else $error("read address not taken");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
endmodule
bind sfo_sync_output sfo_sync_output_chk chk (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.regenHsync, .filtHsync, .dataEnableIn, .pllHsync, .procHsync, .aoSample, .outDataEnable);

// *** verification/sfo_video_sink.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// downstream processor: hsync width and pixel clock rate
// ----------------------------------------
module sfo_video_sink (
	input  wire        clk,
	input  wire        clear,
	input  wire        hsyncIn,
	input  wire        activeHigh,
	input  wire        pixClk,
	output reg  [8:0]  hsyncWidth,
	output reg  [15:0] clkRises
);
	reg [8:0] run;
	reg       clkLast;
	// width of the last active pulse, latched when it ends
	always @(posedge clk) begin
		if (clear || hsyncIn != activeHigh) run <= 9'd0;
		else run <= run + 9'd1;
		if (hsyncIn != activeHigh && run != 9'd0) hsyncWidth <= run;
	end
	// pixel clock is sampled by the system clock, so only rates up to half are seen
	always @(posedge clk) begin
		clkLast <= pixClk;
		if (clear) clkRises <= 16'd0;
		else if (pixClk && !clkLast) clkRises <= clkRises + 16'd1;
	end
endmodule

// *** verification/sfo_sync_output_test.sv ***
`timescale 1ns/1ps
`include "sfo_map.vh"
module sfo_sync_output_test;
	localparam [49:0] ADRS = {`SFO_ADDR_CLK, `SFO_ADDR_POL, `SFO_ADDR_HWID, `SFO_ADDR_VDUR,
		`SFO_ADDR_PATH};
	localparam [39:0] RSTS = {`SFO_RST_CLK, `SFO_RST_POL, `SFO_RST_HWID, `SFO_RST_VDUR,
		`SFO_RST_PATH};
	reg         clk = 1'b0, sys_rst = 1'b1, clear = 1'b0;
	reg [9:0]   s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	reg [31:0]  s_axi_wdata = 32'h0000_0000;
	reg [3:0]   s_axi_wstrb = 4'h0;
	reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, digitalPath = 1'b0;
	reg [1:0]   pixelRepeat = 2'h0;
	reg         rawHsyncPin = 1'b0, rawVsyncPin = 1'b0, greenSyncPin = 1'b0, clampPin = 1'b0;
	reg         regenHsync = 1'b0, filtHsync = 1'b0, dataEnableIn = 1'b0, fieldIn = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        pllHsync, procHsync, aoSample, outHsync, outVsync, outDataEnable, outField;
	wire        green_embedded_sync, outClk;
	wire [8:0]  hsyncWidth;
	wire [15:0] clkRises;
	integer     num_errors = 0, total_checks = 0, cycles = 0;
	sfo_sync_output #(.REP_W(2)) uut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .digitalPath, .pixelRepeat,
		.rawHsyncPin, .rawVsyncPin, .greenSyncPin, .clampPin, .regenHsync, .filtHsync,
		.dataEnableIn, .fieldIn, .pllHsync, .procHsync, .aoSample, .outHsync, .outVsync,
		.outDataEnable, .outField, .green_embedded_sync, .outClk);
	sfo_video_sink sink (.clk, .clear, .hsyncIn(outHsync), .activeHigh(1'b1), .pixClk(outClk),
		.hsyncWidth, .clkRises);
	// clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task axi_wr(input [9:0] a, input [7:0] d, input [3:0] st, input [1:0] er);
		begin
			@(posedge clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h00_0000, d};
			s_axi_wstrb <= st;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!s_axi_bvalid) begin
				@(posedge clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end
			check(s_axi_bresp, er);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd_chk(input [9:0] a, input [31:0] e, input [1:0] er);
		begin
			@(posedge clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			while (!s_axi_rvalid) begin
				@(posedge clk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end
			check(s_axi_rdata, e);
			check(s_axi_rresp, er);
			s_axi_rready <= 1'b0;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		integer i;
		begin
			for (i = 0; i < 5; i = i + 1) rd_chk(ADRS[i*10 +: 10], RSTS[i*8 +: 8], 2'b00);
			rd_chk(10'h200, 32'h0000_0000, 2'b10);
			for (i = 0; i < 5; i = i + 1) begin
				axi_wr(ADRS[i*10 +: 10], 8'h5A + i[7:0], 4'h1, 2'b00);
				rd_chk(ADRS[i*10 +: 10], 8'h5A + i[7:0], 2'b00);
			end
			// a cleared byte strobe leaves the value alone
			axi_wr(`SFO_ADDR_HWID, 8'h00, 4'h0, 2'b00);
			rd_chk(`SFO_ADDR_HWID, 32'h0000_005C, 2'b00);
			axi_wr(`SFO_ADDR_STAT, 8'hFF, 4'h1, 2'b10);
			$display("register test done");
		end
	endtask
	task t_pol;
		integer p;
		begin
			axi_wr(`SFO_ADDR_PATH, `SFO_RST_PATH, 4'h1, 2'b00);
			for (p = 0; p < 2; p = p + 1) begin
				axi_wr(`SFO_ADDR_POL, {{4{p[0]}}, 4'h8}, 4'h1, 2'b00);
				dataEnableIn <= 1'b1;
				tick(6);
				check(outHsync, !p[0]);
				check(outVsync, !p[0]);
				check(outDataEnable, p[0]);
				check(outField, !p[0]);
				dataEnableIn <= 1'b0;
			end
			$display("polarity test done");
		end
	endtask
	task t_hwid;
		integer w;
		begin
			for (w = 1; w < 8; w = w + 4) begin
				axi_wr(`SFO_ADDR_HWID, w[7:0], 4'h1, 2'b00);
				regenHsync <= 1'b1;
				tick(1);
				regenHsync <= 1'b0;
				tick(w + 10);
				check(hsyncWidth, w);
			end
			$display("hsync width test done");
		end
	endtask
	task t_route;
		integer s;
		begin
			filtHsync <= 1'b1;
			regenHsync <= 1'b1;
			tick(3);
			check(pllHsync, 1'b1);
			check(procHsync, 1'b1);
			axi_wr(`SFO_ADDR_PATH, 8'h0C, 4'h1, 2'b00);
			tick(3);
			check(pllHsync, 1'b0);
			check(procHsync, 1'b0);
			axi_wr(`SFO_ADDR_PATH, `SFO_RST_PATH, 4'h1, 2'b00);
			// one source high at a time, so a wrong route reads low
			for (s = 0; s < 4; s = s + 1) begin
				greenSyncPin <= (s == 0);
				rawHsyncPin <= (s == 1);
				regenHsync <= (s == 2);
				filtHsync <= (s == 3);
				axi_wr(`SFO_ADDR_POL, {5'h1F, s[1:0], 1'b0}, 4'h1, 2'b00);
				tick(8);
				check(green_embedded_sync, 1'b1);
				axi_wr(`SFO_ADDR_POL, {5'h1E, s[1:0], 1'b0}, 4'h1, 2'b00);
				tick(3);
				check(green_embedded_sync, 1'b0);
			end
			{greenSyncPin, rawHsyncPin, regenHsync, filtHsync} <= 4'h0;
			$display("routing test done");
		end
	endtask
	task ao_run(input [7:0] pv, output integer dly, output integer len);
		begin
			axi_wr(`SFO_ADDR_PATH, pv, 4'h1, 2'b00);
			clampPin <= 1'b1;
			tick(4);
			clampPin <= 1'b0;
			dly = 0;
			len = 0;
			while (!aoSample) begin
				tick(1);
				dly = dly + 1;
			end
			while (aoSample) begin
				tick(1);
				len = len + 1;
			end
		end
	endtask
	task t_ao;
		integer d0, d1, n;
		begin
			ao_run(8'hC8, d0, n);
			check(n, 6);
			ao_run(8'hCC, d1, n);
			check(d1 - d0, 6);
			axi_wr(`SFO_ADDR_PATH, 8'hC0, 4'h1, 2'b00);
			clampPin <= 1'b1;
			tick(10);
			check(aoSample, 1'b1);
			clampPin <= 1'b0;
			tick(10);
			check(aoSample, 1'b0);
			$display("offset window test done");
		end
	endtask
	// raw vsync spans twelve lines of eight clocks, rising mid-line
	task vs_run(input [7:0] pv, output integer f, output integer n);
		integer k;
		begin
			axi_wr(`SFO_ADDR_PATH, pv, 4'h1, 2'b00);
			f = 0;
			n = 0;
			for (k = 0; k < 192; k = k + 1) begin
				regenHsync <= (k % 8 == 0);
				rawVsyncPin <= (k >= 20 && k < 116);
				tick(1);
				if (outVsync) begin
					if (n == 0) f = k;
					n = n + 1;
				end
			end
		end
	endtask
	task t_vs;
		integer f0, f1, n;
		begin
			axi_wr(`SFO_ADDR_POL, `SFO_RST_POL, 4'h1, 2'b00);
			axi_wr(`SFO_ADDR_VDUR, 8'h03, 4'h1, 2'b00);
			vs_run(8'hCC, f0, n);
			check((n + 4) / 8, 12);
			vs_run(8'hEC, f1, n);
			check(f1 > f0 && f1 <= f0 + 8, 1);
			vs_run(8'hFC, f1, n);
			check((n + 4) / 8, 3);
			$display("vsync test done");
		end
	endtask
	task clk_rate(input [7:0] cv, input [1:0] rep, input [15:0] exp);
		begin
			axi_wr(`SFO_ADDR_CLK, cv, 4'h1, 2'b00);
			pixelRepeat <= rep;
			tick(8);
			clear <= 1'b1;
			tick(1);
			clear <= 1'b0;
			tick(65);
			check(clkRises, exp);
		end
	endtask
	task t_clk;
		begin
			clk_rate(8'h70, 2'd0, 16'd16);
			clk_rate(8'h30, 2'd0, 16'd8);
			clk_rate(8'hF0, 2'd0, 16'd16);
			digitalPath <= 1'b1;
			clk_rate(8'h70, 2'd1, 16'd8);
			digitalPath <= 1'b0;
			clk_rate(8'hB0, 2'd0, 16'd32);
			$display("clock select test done");
		end
	endtask
	// mid-run reset gives both runs the same clock phase, so only the invert bit differs
	task inv_run(input [7:0] pv, output [3:0] pat);
		integer k;
		begin
			sys_rst <= 1'b1;
			tick(3);
			sys_rst <= 1'b0;
			rd_chk(`SFO_ADDR_PATH, `SFO_RST_PATH, 2'b00);
			axi_wr(`SFO_ADDR_POL, pv, 4'h1, 2'b00);
			tick(20);
			for (k = 0; k < 4; k = k + 1) begin
				tick(1);
				pat[k] = outClk;
			end
		end
	endtask
	task t_inv;
		reg [3:0] a;
		reg [3:0] b;
		begin
			inv_run(`SFO_RST_POL, a);
			inv_run(`SFO_RST_POL | 8'h01, b);
			check(b, {28'h000_0000, ~a});
			check(a == 4'h0 || a == 4'hF, 0);
			$display("clock invert test done");
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_pol;
		t_hwid;
		t_route;
		t_ao;
		t_vs;
		t_clk;
		t_inv;
		end_of_test;
	end
endmodule
